// file: common/bhs_pkg.sv
package bhs_pkg;
    // ************************************************************
    // timing counts, in clocks, and the clock period in ns
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned HOLD_LAT_CLK    = 2;
    localparam int unsigned SNOOP_LAT_CLK   = 2;
    localparam int unsigned SNOOP_DIRTY_MATCH_N_TAIL_CLK   = 2;
    localparam int unsigned WB_GAP_CLK      = 2;
    localparam int unsigned ERR_LAT_CLK     = 2;

    localparam logic [1:0] CNT_ZERO = 2'h0;
    localparam logic [1:0] CNT_ONE  = 2'h1;

    // ************************************************************
    // snoop lookup result from the cache side
    // ************************************************************
    typedef struct packed {
        logic hit;       // line valid in either cache
        logic modified;  // line modified in data cache
    } bhs_snoop_t;

    // checker comparison: internal versus sampled pin value
    typedef struct packed {
        logic valid;     // a pin value was returned this clock
        logic differs;   // it differs from the internal result
    } bhs_check_t;

    // ************************************************************
    // bus ownership states
    // ************************************************************
    typedef enum logic [3:0] {
        BHS_OWN    = 4'h1,
        BHS_WAIT   = 4'h2,
        BHS_HELD   = 4'h4,
        BHS_REL    = 4'h8
    } bhs_bus_state_t;
endpackage : bhs_pkg

// file: rtl/bhs_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// R1: sample role input every clock during reset
// R2: role fixed from last reset clock
// R3: system holds role input stable around release
// R4: checker floats outputs, compares pins, flags error
// R5: mismatch pulses error low two clocks later
// R6: snoop match driven two clocks after strobe
// R7: snoop match holds between inquiries, high after reset
// R8: snoop outputs always driven, never floated
// R9: modified hit asserts dirty match, schedules writeback
// R10: dirty match only with snoop match
// R11: writeback strobe two clocks after dirty match
// R12: writeback may start during address hold
// R13: dirty match held until writeback ends plus two
// R14: hold acknowledge two clocks after idle; code acks one clock after idle when a request is already waiting
// R15: acknowledge rises with bus float
// R16: acknowledge drops two clocks after request removal
// R17: pending cycle starts at or after drop
// R18: back-off does not change hold timing
// R19: hold floats same pins as back-off
// R20: inquiries serviced while held
// R21: no grant inside locked sequence
// R22: hold request sampled every clock, even in reset
// R23: core keeps running from caches during hold
// R24: dual-processing bidirectional snoop pins noted only
// R25: master keeps request until acknowledge seen
module bhs_ctrl #(
    parameter bit EXTENDED_VARIANT = 1'b0
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic              i_redundancy_role_select,
    input  wire logic              i_hold_request,
    input  wire logic              i_bus_backoff,
    input  wire logic              i_addr_float_request,
    input  wire logic              i_external_addr_strobe,
    input  wire bhs_pkg::bhs_snoop_t i_snoop,
    input  wire logic              i_burst_ready,
    input  wire logic              i_cycle_busy,
    input  wire logic              i_cycle_last,
    input  wire logic              i_lock_seq,
    input  wire logic              i_cycle_pending,
    input  wire bhs_pkg::bhs_check_t i_check,
    output logic                   o_bus_grant_ack,
    output logic                   o_bus_drive_en,
    output logic                   o_cycle_start_ok,
    output logic                   o_wb_start,
    output logic                   o_snoop_match_n,
    output logic                   o_snoop_dirty_match_n,
    output logic                   o_internal_error_out_n,
    output logic                   o_master_mode
);
    // ************************************************************
    // redundancy role
    // ************************************************************
    logic role_master_r;
    logic is_master_r;

    // role sampled each reset clock, last one sticks on release
    always_ff @(posedge i_clk)
    begin
        if (i_ce && i_rst)
        begin
            role_master_r <= i_redundancy_role_select; // see R1 see R2
        end
    end

    // final role; checker floats bus pins (see R4); R3 is on system
    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            is_master_r   <= i_rst ? i_redundancy_role_select
                                   : role_master_r; // see R2
            o_master_mode <= i_rst ? i_redundancy_role_select
                                   : role_master_r; // see R4
        end
    end

    // ************************************************************
    // checker mismatch reporting
    // ************************************************************
    logic err_seen_r;

    // pulse per mismatch, no shutdown; consecutive mismatches chain
    // one stage plus the output flop, same lag as the snoop outputs
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            err_seen_r             <= 1'b0;
            o_internal_error_out_n <= 1'b1;
        end
        else if (i_ce)
        begin
            err_seen_r <= ~is_master_r & i_check.valid
                          & i_check.differs; // see R4
            o_internal_error_out_n <= ~err_seen_r; // see R5
        end
    end

    // ************************************************************
    // inquire snooping
    // ************************************************************
    logic        external_addr_strobe_d_r;
    bhs_pkg::bhs_snoop_t snp_d_r;
    logic        wb_pend_r;
    logic        wb_act_r;
    logic [1:0]  gap_cnt_r;
    logic [1:0]  tail_cnt_r;
    logic        tail_r;
    logic        wb_done;
    logic        external_addr_strobe_hit2;
    logic        snp_busy;

    localparam logic [1:0] CNT_ONE_L = bhs_pkg::CNT_ONE;
    localparam logic [1:0] GAP_INIT  = 2'(bhs_pkg::WB_GAP_CLK - 1);
    // output flop supplies the second clock of the tail
    localparam logic [1:0] TAIL_INIT = 2'(bhs_pkg::SNOOP_DIRTY_MATCH_N_TAIL_CLK - 1);

    // one stage delay, result drives outputs on the second edge
    assign external_addr_strobe_hit2 = external_addr_strobe_d_r;
    // writeback in flight: inquiries dropped so both outputs agree
    assign snp_busy  = wb_pend_r | wb_act_r | tail_r;
    assign wb_done   = wb_act_r & i_burst_ready & i_cycle_last;

    // strobe stays recognized during hold; only the writeback busy term gates it here
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            external_addr_strobe_d_r <= 1'b0;
            snp_d_r  <= '0;
        end
        else if (i_ce)
        begin
            external_addr_strobe_d_r <= i_external_addr_strobe && !snp_busy; // see R20
            snp_d_r  <= i_snoop;
        end
    end

    // snoop match: changes only on an inquiry, never floated
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_snoop_match_n <= 1'b1; // see R7
        end
        else if (i_ce && external_addr_strobe_hit2 && !snp_busy)
        begin
            o_snoop_match_n <= ~snp_d_r.hit; // see R6 see R8
        end
    end

    // dirty match set on modified hit, held to tail of writeback
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_snoop_dirty_match_n <= 1'b1;
        end
        else if (i_ce)
        begin
            if (external_addr_strobe_hit2 && !snp_busy)
            begin
                // modified implies hit, so match is low too
                o_snoop_dirty_match_n <= ~(snp_d_r.modified
                                           & snp_d_r.hit); // see R9 see R10
            end
            else if (tail_r && tail_cnt_r == CNT_ONE_L)
            begin
                o_snoop_dirty_match_n <= 1'b1; // see R13
            end
        end
    end

    // writeback scheduling: gap after dirty match, then run
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wb_pend_r  <= 1'b0;
            wb_act_r   <= 1'b0;
            gap_cnt_r  <= bhs_pkg::CNT_ZERO;
            tail_r     <= 1'b0;
            tail_cnt_r <= bhs_pkg::CNT_ZERO;
            o_wb_start <= 1'b0;
        end
        else if (i_ce)
        begin
            o_wb_start <= 1'b0;
            if (external_addr_strobe_hit2 && snp_d_r.modified && snp_d_r.hit
                && !wb_pend_r && !wb_act_r && !tail_r)
            begin
                wb_pend_r <= 1'b1; // see R9
                gap_cnt_r <= GAP_INIT;
            end
            else if (wb_pend_r)
            begin
                if (gap_cnt_r != bhs_pkg::CNT_ZERO)
                begin
                    gap_cnt_r <= gap_cnt_r - CNT_ONE_L; // see R11
                end
                else if (!o_bus_grant_ack && !i_cycle_busy)
                begin
                    // allowed even with address hold asserted
                    wb_pend_r  <= 1'b0;
                    wb_act_r   <= 1'b1;
                    o_wb_start <= 1'b1; // see R12
                end
            end
            if (wb_done)
            begin
                wb_act_r   <= 1'b0;
                tail_r     <= 1'b1;
                tail_cnt_r <= TAIL_INIT; // see R13
            end
            else if (tail_r)
            begin
                tail_cnt_r <= tail_cnt_r - CNT_ONE_L;
                if (tail_cnt_r == CNT_ONE_L)
                begin
                    tail_r <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // bus hold handshake
    // ************************************************************
    bhs_pkg::bhs_bus_state_t st_r;
    bhs_pkg::bhs_bus_state_t st_nxt;
    logic hold_d_r;
    logic bus_quiet;
    logic rel_d_r;

    // request sampled every edge, reset included (see R22)
    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            hold_d_r <= i_hold_request; // see R22
        end
    end

    // no grant while a cycle, locked run or writeback is open
    assign bus_quiet = !i_cycle_busy && !i_lock_seq && !wb_act_r
                       && !wb_pend_r; // see R21

    // back-off is deliberately not a term here (see R18)
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            bhs_pkg::BHS_OWN:
                if (hold_d_r && bus_quiet)
                    st_nxt = bhs_pkg::BHS_HELD; // see R14 see R18
                else if (hold_d_r)
                    st_nxt = bhs_pkg::BHS_WAIT;
            bhs_pkg::BHS_WAIT:
                if (!hold_d_r)
                    st_nxt = bhs_pkg::BHS_OWN;
                else if (bus_quiet)
                    st_nxt = bhs_pkg::BHS_HELD; // see R14
            bhs_pkg::BHS_HELD:
                if (!hold_d_r)
                    st_nxt = bhs_pkg::BHS_OWN; // see R16 see R18
            default:
                st_nxt = bhs_pkg::BHS_OWN;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_r <= bhs_pkg::BHS_OWN;
        end
        else if (i_ce)
        begin
            st_r <= st_nxt;
        end
    end

    // float comes with ack, and also with back-off or checker role; core runs on (see R23)
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_bus_grant_ack <= 1'b0;
            o_bus_drive_en  <= 1'b0;
            rel_d_r         <= 1'b0;
        end
        else if (i_ce)
        begin
            o_bus_grant_ack <= (st_nxt == bhs_pkg::BHS_HELD); // see R15
            // address, data, parity, control float same as back-off
            o_bus_drive_en  <= is_master_r && st_nxt != bhs_pkg::BHS_HELD
                               && !i_bus_backoff; // see R19 see R4
            rel_d_r <= o_bus_grant_ack && st_nxt != bhs_pkg::BHS_HELD;
        end
    end

    // pending cycle launch: base at drop, extended one clock later
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_cycle_start_ok <= 1'b0;
        end
        else if (i_ce)
        begin
            o_cycle_start_ok <= st_nxt != bhs_pkg::BHS_HELD
                && !(EXTENDED_VARIANT
                     && o_bus_grant_ack) // see R17
                && !i_bus_backoff
                && !(i_addr_float_request && !wb_act_r); // see R12
        end
    end
    // dual-processing pins not built (see R24); R25 kept by master
endmodule : bhs_ctrl

// file: testbench/bhs_ctrl_checker.sv
`timescale 1ns/1ps
// ****************************************
// hold, snoop and checker-mode port checks
// ****************************************
module bhs_ctrl_checker (
    input wire logic                i_clk,
    input wire logic                i_rst,
    input wire logic                i_redundancy_role_select,
    input wire logic                i_hold_request,
    input wire logic                i_external_addr_strobe,
    input wire bhs_pkg::bhs_snoop_t i_snoop,
    input wire logic                i_burst_ready,
    input wire logic                i_cycle_last,
    input wire bhs_pkg::bhs_check_t i_check,
    input wire logic                o_bus_grant_ack,
    input wire logic                o_bus_drive_en,
    input wire logic                o_wb_start,
    input wire logic                o_snoop_match_n,
    input wire logic                o_snoop_dirty_match_n,
    input wire logic                o_internal_error_out_n,
    input wire logic                o_master_mode
);
    // short aliases; inquiries while dirty is low are ignored by design
    wire logic stb = i_external_addr_strobe && o_snoop_dirty_match_n;
    wire logic mis = i_check.valid && i_check.differs;
    wire logic dmn = o_snoop_dirty_match_n;
    wire logic ack = o_bus_grant_ack;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_snoop_hit: assert property (
        stb && i_snoop.hit |-> ##2 !o_snoop_match_n)
        else $error("hit not reported");
    a_snoop_miss: assert property (
        stb && !i_snoop.hit |-> ##2 o_snoop_match_n && dmn)
        else $error("miss not reported");
    a_dirty_hit: assert property (
        stb && i_snoop.hit && i_snoop.modified |-> ##2 !dmn)
        else $error("dirty hit not reported");
    a_match_cause: assert property (
        $changed(o_snoop_match_n) |-> $past(stb, 2))
        else $error("match changed without inquiry");
    a_dirty_match: assert property (
        !dmn |-> !o_snoop_match_n)
        else $error("dirty without match");
    a_wb_gap: assert property (
        o_wb_start |-> !$past(dmn, 2))
        else $error("writeback too soon");
    a_dirty_tail: assert property (
        $rose(dmn) |-> $past(i_burst_ready, 2) && $past(i_cycle_last, 2))
        else $error("dirty released early");
    a_ack_rise: assert property (
        $rose(ack) |-> $past(i_hold_request, 2))
        else $error("ack without request");
    a_ack_drop: assert property (
        $fell(ack) |-> !$past(i_hold_request, 2))
        else $error("ack dropped early");
    a_ack_float: assert property (
        ack |-> !o_bus_drive_en)
        else $error("bus driven while held");
    a_check_float: assert property (
        !o_master_mode |-> !o_bus_drive_en)
        else $error("checker drives bus");
    a_err_delay: assert property (
        mis && !o_master_mode |-> ##2 !o_internal_error_out_n)
        else $error("mismatch not flagged");
    a_role_latch: assert property (disable iff (1'b0)
        $past(i_rst) |-> o_master_mode == $past(i_redundancy_role_select))
        else $error("role not sampled");
    c_hold: cover property ($rose(ack));
    c_wb: cover property (o_wb_start);
    c_err: cover property (!o_internal_error_out_n);
endmodule : bhs_ctrl_checker

bind bhs_ctrl bhs_ctrl_checker u_chk (.i_clk, .i_rst,
    .i_redundancy_role_select, .i_hold_request, .i_external_addr_strobe,
    .i_snoop, .i_burst_ready, .i_cycle_last, .i_check, .o_bus_grant_ack,
    .o_bus_drive_en, .o_wb_start, .o_snoop_match_n, .o_snoop_dirty_match_n,
    .o_internal_error_out_n, .o_master_mode);

// file: testbench/bhs_master_model.sv
`timescale 1ns/1ps
// other local bus master asking for the bus
module bhs_master_model (
    input  wire logic i_clk,
    input  wire logic i_want,
    input  wire logic i_ack,
    output logic      o_hold_request
);
    // request kept until ack is seen, so no grant is lost
    initial o_hold_request = 1'b0;
    always @(negedge i_clk)
    begin
        if (i_want)
            o_hold_request <= 1'b1;
        else if (i_ack)
            o_hold_request <= 1'b0;
    end
endmodule : bhs_master_model

// file: testbench/test_bus_hold_snoop_checker_ctrl.sv
`timescale 1ns/1ps
// ****************************************
// bench: hold, inquiry and redundancy role
// ****************************************
module test_bus_hold_snoop_checker_ctrl;
    logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
    logic i_redundancy_role_select = 1'b1, i_hold_request;
    logic i_bus_backoff = 1'b0, i_addr_float_request = 1'b0;
    logic i_external_addr_strobe = 1'b0, i_burst_ready = 1'b0;
    logic i_cycle_busy = 1'b0, i_cycle_last = 1'b0, i_lock_seq = 1'b0;
    logic i_cycle_pending = 1'b0, want = 1'b0, prev_m = 1'b1;
    bhs_pkg::bhs_snoop_t i_snoop = 2'h0;
    bhs_pkg::bhs_check_t i_check = 2'h0;
    logic o_bus_grant_ack, o_bus_drive_en, o_cycle_start_ok, o_wb_start;
    logic o_snoop_match_n, o_snoop_dirty_match_n, o_internal_error_out_n;
    logic o_master_mode;
    int   failures = 0;
    int   num_checks = 0;

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    bhs_ctrl #(.EXTENDED_VARIANT(1'b0)) uut (
        .i_clk                    (i_clk),
        .i_rst                    (i_rst),
        .i_ce                     (i_ce),
        .i_redundancy_role_select (i_redundancy_role_select),
        .i_hold_request           (i_hold_request),
        .i_bus_backoff            (i_bus_backoff),
        .i_addr_float_request     (i_addr_float_request),
        .i_external_addr_strobe   (i_external_addr_strobe),
        .i_snoop                  (i_snoop),
        .i_burst_ready            (i_burst_ready),
        .i_cycle_busy             (i_cycle_busy),
        .i_cycle_last             (i_cycle_last),
        .i_lock_seq               (i_lock_seq),
        .i_cycle_pending          (i_cycle_pending),
        .i_check                  (i_check),
        .o_bus_grant_ack          (o_bus_grant_ack),
        .o_bus_drive_en           (o_bus_drive_en),
        .o_cycle_start_ok         (o_cycle_start_ok),
        .o_wb_start               (o_wb_start),
        .o_snoop_match_n          (o_snoop_match_n),
        .o_snoop_dirty_match_n    (o_snoop_dirty_match_n),
        .o_internal_error_out_n   (o_internal_error_out_n),
        .o_master_mode            (o_master_mode)
    );
    bhs_master_model u_master (.i_clk(i_clk), .i_want(want),
        .i_ack(o_bus_grant_ack), .o_hold_request(i_hold_request));

    task automatic chk(input string n, input logic s, input logic e);
        num_checks++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value %s expected %b seen %b", n, e, s);
        end
    endtask : chk

    task automatic nclk(input int n);
        repeat (n) @(negedge i_clk);
    endtask : nclk

    task automatic do_reset(input logic role);
        i_rst = 1'b1;
        i_redundancy_role_select = ~role;
        nclk(2);
        chk("role in reset", o_master_mode, ~role);
        i_redundancy_role_select = role;
        nclk(10);
        i_rst = 1'b0;
        nclk(1);
        // role moves only after the last reset edge
        i_redundancy_role_select = ~role;
        nclk(2);
        chk("role kept", o_master_mode, role);
        chk("match reset", o_snoop_match_n, 1'b1);
        prev_m = 1'b1;
    endtask : do_reset

    task automatic t_snoop(input logic hit, input logic mod);
        i_external_addr_strobe = 1'b1;
        i_snoop = {hit, mod};
        nclk(1);
        i_external_addr_strobe = 1'b0;
        i_snoop = 2'h0;
        chk("match early", o_snoop_match_n, prev_m);
        nclk(1);
        chk("match", o_snoop_match_n, ~hit);
        chk("dirty", o_snoop_dirty_match_n, ~mod);
        prev_m = ~hit;
        if (mod)
        begin
            nclk(1);
            chk("wb early", o_wb_start, 1'b0);
            nclk(1);
            chk("wb", o_wb_start, 1'b1);
            nclk(1);
            i_burst_ready = 1'b1;
            i_cycle_last = 1'b1;
            nclk(1);
            i_burst_ready = 1'b0;
            i_cycle_last = 1'b0;
            chk("dirty held", o_snoop_dirty_match_n, 1'b0);
            nclk(1);
            chk("dirty end", o_snoop_dirty_match_n, 1'b1);
        end
    endtask : t_snoop

    task automatic t_hold(input logic busy, input logic lock, input logic bo);
        i_cycle_busy = busy;
        i_lock_seq = lock;
        i_bus_backoff = bo;
        i_cycle_pending = 1'b1;
        want <= 1'b1;
        nclk(1);
        if (busy | lock)
        begin
            nclk(4);
            chk("ack refused", o_bus_grant_ack, 1'b0);
            i_burst_ready = busy;
            i_cycle_last = busy;
            nclk(1);
            // busy cycle ends with its last burst-ready; locked run just drops lock
            i_burst_ready = 1'b0;
            i_cycle_last = 1'b0;
            i_cycle_busy = 1'b0;
            i_lock_seq = 1'b0;
        end
        else
            nclk(1);
        chk("ack early", o_bus_grant_ack, 1'b0);
        nclk(1);
        chk("ack", o_bus_grant_ack, 1'b1);
        chk("float", o_bus_drive_en, 1'b0);
        t_snoop(prev_m, 1'b0);
        want <= 1'b0;
        nclk(2);
        chk("ack held", o_bus_grant_ack, 1'b1);
        nclk(1);
        chk("ack drop", o_bus_grant_ack, 1'b0);
        chk("drive", o_bus_drive_en, ~bo);
        chk("start", o_cycle_start_ok, ~bo);
        i_bus_backoff = 1'b0;
        i_cycle_pending = 1'b0;
        nclk(2);
    endtask : t_hold

    task automatic t_frc;
        chk("checker float", o_bus_drive_en, 1'b0);
        i_check = 2'h3;
        nclk(1);
        i_check = 2'h0;
        chk("err early", o_internal_error_out_n, 1'b1);
        nclk(1);
        chk("err", o_internal_error_out_n, 1'b0);
        nclk(1);
        chk("err once", o_internal_error_out_n, 1'b1);
    endtask : t_frc

    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // main sequence; address hold stays up over the writeback
    initial
    begin
        do_reset(1'b1);
        t_snoop(1'b1, 1'b0);
        t_snoop(1'b0, 1'b0);
        i_addr_float_request = 1'b1;
        t_snoop(1'b1, 1'b1);
        i_addr_float_request = 1'b0;
        t_snoop(1'b0, 1'b0);
        t_hold(1'b0, 1'b0, 1'b0);
        t_hold(1'b1, 1'b0, 1'b0);
        t_hold(1'b0, 1'b1, 1'b0);
        t_hold(1'b0, 1'b0, 1'b1);
        do_reset(1'b0);
        t_frc;
        end_of_test;
    end
endmodule : test_bus_hold_snoop_checker_ctrl
